/* verilog/dual_8bit_interval_timer.v */
// Dual 8-bit interval timer with Avalon-MM register slave and shared interrupt
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

module dual_8bit_interval_timer #(
  parameter ADDR_W = 16,
  parameter DATA_W = 32
) (
  input  wire              clk_in,
  input  wire              rst_n_in,
  input  wire [ADDR_W-1:0] address_in,
  input  wire              read_in,
  input  wire              write_in,
  input  wire [DATA_W-1:0] writedata_in,
  input  wire [3:0]        byteenable_in,
  output reg  [DATA_W-1:0] readdata_out,
  output reg               waitrequest_out,
  output reg               irq_out,
  output wire              first_overflow_out,
  output wire              second_overflow_out
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg  [7:0] dual_timer_control;
  reg  [7:0] first_timer_period;
  reg  [7:0] second_timer_period;
  reg  [1:0] event_status;
  reg  [1:0] event_mask;

  // --------------------------------------------------------------------------
  // Control register fields
  // --------------------------------------------------------------------------
  wire [1:0] first_clock_select;
  wire [1:0] second_clock_select;
  wire       first_overflow_flag;
  wire       second_overflow_flag;
  wire       first_irq_enable;
  wire       second_irq_enable;
  wire       first_running;
  wire       second_running;

  // Field split of the control byte
  assign first_clock_select   = {dual_timer_control[`FIRST_CLOCK_SELECT_HI],
                                 dual_timer_control[`FIRST_CLOCK_SELECT_LO]};
  assign second_clock_select  = {dual_timer_control[`SECOND_CLOCK_SELECT_HI],
                                 dual_timer_control[`SECOND_CLOCK_SELECT_LO]};
  assign first_overflow_flag  = dual_timer_control[`FIRST_OVERFLOW_FLAG_BIT];
  assign second_overflow_flag = dual_timer_control[`SECOND_OVERFLOW_FLAG_BIT];
  assign first_irq_enable     = dual_timer_control[`FIRST_IRQ_ENABLE_BIT];
  assign second_irq_enable    = dual_timer_control[`SECOND_IRQ_ENABLE_BIT];

  // A timer runs whenever its select is not the stop code
  assign first_running  = (first_clock_select != `CLOCK_SELECT_STOP);
  assign second_running = (second_clock_select != `CLOCK_SELECT_STOP);

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  wire       request;
  wire       accept;
  wire       commit_write;
  wire [7:0] write_byte;

  // A request is answered one cycle after it is seen; the write lands then
  assign request      = read_in || write_in;
  assign accept       = request && waitrequest_out;
  assign commit_write = write_in && !waitrequest_out && byteenable_in[0];
  assign write_byte   = writedata_in[7:0];

  // --------------------------------------------------------------------------
  // Address decode of committed writes
  // --------------------------------------------------------------------------
  wire write_control;
  wire write_first_period;
  wire write_second_period;
  wire write_event_status;
  wire write_event_mask;

  // One strobe per writable register
  assign write_control       = commit_write && (address_in == `ADDR_DUAL_TIMER_CONTROL);
  assign write_first_period  = commit_write && (address_in == `ADDR_FIRST_TIMER_PERIOD);
  assign write_second_period = commit_write && (address_in == `ADDR_SECOND_TIMER_PERIOD);
  assign write_event_status  = commit_write && (address_in == `ADDR_EVENT_STATUS);
  assign write_event_mask    = commit_write && (address_in == `ADDR_EVENT_MASK);

  // --------------------------------------------------------------------------
  // Timer channels
  // --------------------------------------------------------------------------
  wire [7:0] first_counter;
  wire [7:0] second_counter;
  wire       first_restart;
  wire       second_restart;
  wire       first_wrap;
  wire       second_wrap;

  // Period reload while running restarts that channel only
  assign first_restart  = write_first_period && first_running;
  assign second_restart = write_second_period && second_running;

  // First timer, steered by control bits 5:4
  interval_channel #(
    .CNT_W (8),
    .PRE_W (6)
  ) first_timer (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .clock_select_in (first_clock_select),
    .period_in       (first_timer_period),
    .restart_in      (first_restart),
    .count_out       (first_counter),
    .overflow_out    (first_wrap)
  );

  // Second timer, steered by control bits 7:6
  interval_channel #(
    .CNT_W (8),
    .PRE_W (6)
  ) second_timer (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n_in),
    .clock_select_in (second_clock_select),
    .period_in       (second_timer_period),
    .restart_in      (second_restart),
    .count_out       (second_counter),
    .overflow_out    (second_wrap)
  );

  // Wrap pulses leave straight from the channel flip-flops
  assign first_overflow_out  = first_wrap;
  assign second_overflow_out = second_wrap;

  // --------------------------------------------------------------------------
  // Next control register value
  // --------------------------------------------------------------------------
  reg [7:0] next_control;

  // Software value where written; an overflow always sets its flag
  always @* begin
    next_control = dual_timer_control;
    if (write_control) begin
      next_control = write_byte;
    end
    if (first_wrap) begin
      next_control[`FIRST_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    if (second_wrap) begin
      next_control[`SECOND_OVERFLOW_FLAG_BIT] = 1'b1;
    end
  end

  // Control register; flags are never cleared by hardware
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dual_timer_control <= `RESET_CONTROL;
    end else begin
      dual_timer_control <= next_control;
    end
  end

  // --------------------------------------------------------------------------
  // Period registers
  // --------------------------------------------------------------------------
  // Plain read and write storage, used by the channel at once
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_timer_period  <= `RESET_PERIOD;
      second_timer_period <= `RESET_PERIOD;
    end else begin
      if (write_first_period) begin
        first_timer_period <= write_byte;
      end
      if (write_second_period) begin
        second_timer_period <= write_byte;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event status and mask
  // --------------------------------------------------------------------------
  reg [1:0] next_event_status;
  reg [1:0] event_set;
  reg [1:0] event_clear;

  // Sticky events, write one to clear, a new event wins the same cycle
  always @* begin
    event_set                    = 2'h0;
    event_set[`EVENT_FIRST_BIT]  = first_wrap;
    event_set[`EVENT_SECOND_BIT] = second_wrap;
    event_clear                  = write_event_status ? write_byte[1:0] : 2'h0;
    next_event_status            = (event_status & ~event_clear) | event_set;
  end

  // Status and mask storage
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_status <= `RESET_EVENT;
      event_mask   <= `RESET_EVENT;
    end else begin
      event_status <= next_event_status;
      if (write_event_mask) begin
        event_mask <= write_byte[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------------------
  wire first_request;
  wire second_request;
  wire event_request;
  wire next_irq;

  // Flag with its enable, or any unmasked sticky event, asks for service
  assign first_request  = first_overflow_flag && first_irq_enable;
  assign second_request = second_overflow_flag && second_irq_enable;
  assign event_request  = |(event_status & event_mask);
  assign next_irq       = first_request || second_request || event_request;

  // Registered level output
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= next_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Read-back multiplexer
  // --------------------------------------------------------------------------
  reg [7:0] read_byte;

  // Unmapped indexes read as zero; upper bits always zero
  always @* begin
    case (address_in)
      `ADDR_DUAL_TIMER_CONTROL:  read_byte = dual_timer_control;
      `ADDR_FIRST_TIMER_PERIOD:  read_byte = first_timer_period;
      `ADDR_SECOND_TIMER_PERIOD: read_byte = second_timer_period;
      `ADDR_EVENT_STATUS:        read_byte = {6'h00, event_status};
      `ADDR_EVENT_MASK:          read_byte = {6'h00, event_mask};
      `ADDR_FIRST_COUNT:         read_byte = first_counter;
      `ADDR_SECOND_COUNT:        read_byte = second_counter;
      default:                   read_byte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------------
  // Wait high at rest; drops for exactly one cycle per request
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      waitrequest_out <= 1'b1;
    end else if (accept) begin
      waitrequest_out <= 1'b0;
    end else begin
      waitrequest_out <= 1'b1;
    end
  end

  // Read data captured as the answer is given, held until the next read
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      readdata_out <= {DATA_W{1'b0}};
    end else if (accept && read_in) begin
      readdata_out <= {{(DATA_W-8){1'b0}}, read_byte};
    end
  end

endmodule // dual_8bit_interval_timer

/* common/dual_timer_consts.vh */
// Constants for the dual 8-bit interval timer: offsets, fields, resets, prescale counts
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH

// ----------------------------------------------------------------------------
// Register indexes (word address on the bus, byte address is four times this)
// ----------------------------------------------------------------------------
`define ADDR_DUAL_TIMER_CONTROL   16'hFE3C
`define ADDR_FIRST_TIMER_PERIOD   16'hFE3E
`define ADDR_SECOND_TIMER_PERIOD  16'hFE3F
`define ADDR_EVENT_STATUS         16'hFE40
`define ADDR_EVENT_MASK           16'hFE41
`define ADDR_FIRST_COUNT          16'hFE44
`define ADDR_SECOND_COUNT         16'hFE45

// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define FIRST_IRQ_ENABLE_BIT      0
`define FIRST_OVERFLOW_FLAG_BIT   1
`define SECOND_IRQ_ENABLE_BIT     2
`define SECOND_OVERFLOW_FLAG_BIT  3
`define FIRST_CLOCK_SELECT_LO     4
`define FIRST_CLOCK_SELECT_HI     5
`define SECOND_CLOCK_SELECT_LO    6
`define SECOND_CLOCK_SELECT_HI    7

// ----------------------------------------------------------------------------
// Event status and mask layout
// ----------------------------------------------------------------------------
`define EVENT_FIRST_BIT           0
`define EVENT_SECOND_BIT          1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RESET_CONTROL             8'h00
`define RESET_PERIOD              8'h00
`define RESET_EVENT               2'h0

// ----------------------------------------------------------------------------
// Clock select codes and last prescaler value of each division
// ----------------------------------------------------------------------------
`define CLOCK_SELECT_STOP         2'h0
`define CLOCK_SELECT_DIV4         2'h1
`define CLOCK_SELECT_DIV16        2'h2
`define CLOCK_SELECT_DIV64        2'h3
`define PRESCALE_LAST_DIV4        6'h03
`define PRESCALE_LAST_DIV16       6'h0F
`define PRESCALE_LAST_DIV64       6'h3F

`endif

/* verilog/interval_channel.v */
// One 8-bit interval timer with its own 6-bit prescaler
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

module interval_channel #(
  parameter CNT_W = 8,
  parameter PRE_W = 6
) (
  input  wire             clk_in,
  input  wire             rst_n_in,
  input  wire [1:0]       clock_select_in,
  input  wire [CNT_W-1:0] period_in,
  input  wire             restart_in,
  output reg  [CNT_W-1:0] count_out,
  output reg              overflow_out
);

  // --------------------------------------------------------------------------
  // Prescaler terminal value
  // --------------------------------------------------------------------------
  reg  [PRE_W-1:0] prescaler;
  reg  [PRE_W-1:0] terminal;
  wire             running;
  wire             count_tick;

  // Last prescaler value for the selected division
  always @* begin
    case (clock_select_in)
      `CLOCK_SELECT_DIV4:  terminal = `PRESCALE_LAST_DIV4;
      `CLOCK_SELECT_DIV16: terminal = `PRESCALE_LAST_DIV16;
      `CLOCK_SELECT_DIV64: terminal = `PRESCALE_LAST_DIV64;
      default:             terminal = `PRESCALE_LAST_DIV64;
    endcase
  end

  assign running    = (clock_select_in != `CLOCK_SELECT_STOP);
  assign count_tick = running && (prescaler == terminal);

  // --------------------------------------------------------------------------
  // Prescaler and counter
  // --------------------------------------------------------------------------
  // Stop code or period reload clears both; wrap after the period value
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescaler    <= {PRE_W{1'b0}};
      count_out    <= {CNT_W{1'b0}};
      overflow_out <= 1'b0;
    end else if (!running || restart_in) begin
      prescaler    <= {PRE_W{1'b0}};
      count_out    <= {CNT_W{1'b0}};
      overflow_out <= 1'b0;
    end else if (count_tick) begin
      prescaler <= {PRE_W{1'b0}};
      if (count_out == period_in) begin
        count_out    <= {CNT_W{1'b0}};
        overflow_out <= 1'b1;
      end else begin
        count_out    <= count_out + {{(CNT_W-1){1'b0}}, 1'b1};
        overflow_out <= 1'b0;
      end
    end else begin
      prescaler    <= prescaler + {{(PRE_W-1){1'b0}}, 1'b1};
      overflow_out <= 1'b0;
    end
  end

endmodule // interval_channel

/* testbench/dual_timer_checker_assertions.sv */
// Checker for bus handshake, wrap pulses and interrupt of the dual interval timer
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

module dual_timer_checker #(
  parameter ADDR_W = 16,
  parameter DATA_W = 32
) (
  input wire              clk_in,
  input wire              rst_n_in,
  input wire [ADDR_W-1:0] address_in,
  input wire              read_in,
  input wire              write_in,
  input wire [DATA_W-1:0] writedata_in,
  input wire [3:0]        byteenable_in,
  input wire [DATA_W-1:0] readdata_out,
  input wire              waitrequest_out,
  input wire              irq_out,
  input wire              first_overflow_out,
  input wire              second_overflow_out
);
  default clocking dflt @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // --------------------------------------------------------------------------
  // Shadow of software-owned control bits and event mask
  // --------------------------------------------------------------------------
  reg  [7:0] ctl;
  reg  [1:0] msk;
  wire       wr_ok = write_in && !waitrequest_out && byteenable_in[0];
  wire [3:0] irq_src = {ctl[2], ctl[0], msk};

  // Commit at the same edge as the design
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl <= 8'h00;
      msk <= 2'h0;
    end else if (wr_ok && address_in == `ADDR_DUAL_TIMER_CONTROL) begin
      ctl <= writedata_in[7:0];
    end else if (wr_ok && address_in == `ADDR_EVENT_MASK) begin
      msk <= writedata_in[1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  answer_in_one_a: assert property ((read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("bus request not answered in one cycle");
  wait_one_cycle_a: assert property (!waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!read_in && !write_in |=> waitrequest_out)
    else $error("waitrequest low without request");
  upper_zero_a: assert property (readdata_out[DATA_W-1:8] == '0)
    else $error("read data upper bits not zero");
  pulse_gap_a: assert property (first_overflow_out |=> !first_overflow_out [*3])
    else $error("first wrap pulses closer than four cycles");
  stop_first_a: assert property (ctl[5:4] == 2'h0 && $past(ctl[5:4]) == 2'h0 |-> !first_overflow_out)
    else $error("first timer wraps while stopped");
  stop_second_a: assert property (ctl[7:6] == 2'h0 && $past(ctl[7:6]) == 2'h0 |-> !second_overflow_out)
    else $error("second timer wraps while stopped");
  irq_first_a: assert property (first_overflow_out && ctl[0] && !write_in ##1 !write_in |=> irq_out)
    else $error("no interrupt after enabled first overflow");
  irq_second_a: assert property (second_overflow_out && ctl[2] && !write_in ##1 !write_in |=> irq_out)
    else $error("no interrupt after enabled second overflow");
  irq_quiet_a: assert property (irq_src == 4'h0 && $past(irq_src) == 4'h0 |-> !irq_out)
    else $error("interrupt while all sources disabled");

  cover property (first_overflow_out);
  cover property (second_overflow_out);
  cover property ($rose(irq_out));
endmodule // dual_timer_checker

bind dual_8bit_interval_timer dual_timer_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address_in), .read_in(read_in),
  .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .irq_out(irq_out),
  .first_overflow_out(first_overflow_out), .second_overflow_out(second_overflow_out));

/* testbench/tb_dual_8bit_interval_timer.sv */
// Self-checking bench for the dual 8-bit interval timer
`timescale 1ns/1ps
`include "dual_timer_consts.vh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module tb_dual_8bit_interval_timer;
  reg         clk_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg  [15:0] address_in = 16'h0000;
  reg         read_in = 1'b0;
  reg         write_in = 1'b0;
  reg  [31:0] writedata_in = 32'h00000000;
  reg  [3:0]  byteenable_in = 4'hF;
  wire [31:0] readdata_out;
  wire        waitrequest_out, irq_out, first_overflow_out, second_overflow_out;
  reg  [31:0] rd;
  int         n_fail = 0, comparisons = 0;

  dual_8bit_interval_timer dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .irq_out(irq_out),
    .first_overflow_out(first_overflow_out), .second_overflow_out(second_overflow_out));

  // --------------------------------------------------------------------------
  // Clock, bus cycle and pulse wait
  // --------------------------------------------------------------------------
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end

  // One Avalon transfer, held until waitrequest is sampled low; only the watchdog ends a hang
  task bus(input wr, input [15:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      address_in <= a;
      writedata_in <= {24'h000000, d};
      write_in <= wr;
      read_in <= !wr;
      do @(posedge clk_in); while (waitrequest_out !== 1'b0);
      rd = readdata_out;
      write_in <= 1'b0;
      read_in <= 1'b0;
    end
  endtask

  // Edges until a wrap pulse is sampled
  task wait_pulse(input sec, output int n);
    begin
      n = 0;
      do begin @(posedge clk_in); n++; end
      while ((sec ? second_overflow_out : first_overflow_out) !== 1'b1 && n < 20000);
      if (n >= 20000) n_fail++;
    end
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task t_regs;
    begin
      bus(0, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
      `CHK("control reset", 32'h00000000, rd)
      bus(0, `ADDR_FIRST_TIMER_PERIOD, 8'h00);
      `CHK("first period reset", 32'h00000000, rd)
      bus(0, `ADDR_SECOND_TIMER_PERIOD, 8'h00);
      `CHK("second period reset", 32'h00000000, rd)
      bus(1, 16'hFE3D, 8'hFF);
      bus(0, 16'hFE3D, 8'h00);
      `CHK("unmapped", 32'h00000000, rd)
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'hA5);
      bus(1, `ADDR_SECOND_TIMER_PERIOD, 8'h5A);
      byteenable_in <= 4'hE;
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'h77);
      byteenable_in <= 4'hF;
      bus(0, `ADDR_FIRST_TIMER_PERIOD, 8'h00);
      `CHK("first period", 32'h000000A5, rd)
      bus(0, `ADDR_SECOND_TIMER_PERIOD, 8'h00);
      `CHK("second period", 32'h0000005A, rd)
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h05);
      bus(0, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
      `CHK("control", 32'h00000005, rd)
    end
  endtask

  // Every division on both timers at once, then both stopped
  task t_rates;
    int c, s, n;
    begin
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'h02);
      bus(1, `ADDR_SECOND_TIMER_PERIOD, 8'h01);
      for (c = 1; c <= 3; c++) begin
        s = (c == 3) ? 1 : c + 1;
        bus(1, `ADDR_DUAL_TIMER_CONTROL, {s[1:0], c[1:0], 4'h0});
        wait_pulse(0, n);
        wait_pulse(0, n);
        `CHK("first gap", 3 * (4 ** c), n)
        wait_pulse(1, n);
        wait_pulse(1, n);
        `CHK("second gap", 2 * (4 ** s), n)
      end
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
      n = 0;
      // A wrap launched at the commit edge itself is still legal
      @(posedge clk_in);
      repeat (300) begin
        @(posedge clk_in);
        if (first_overflow_out !== 1'b0 || second_overflow_out !== 1'b0) n++;
      end
      `CHK("pulses while stopped", 0, n)
      bus(0, `ADDR_FIRST_COUNT, 8'h00);
      `CHK("first count stopped", 32'h00000000, rd)
      bus(0, `ADDR_SECOND_COUNT, 8'h00);
      `CHK("second count stopped", 32'h00000000, rd)
    end
  endtask

  // Flags, enables, mask and sticky events
  task t_irq;
    int n;
    begin
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'h00);
      bus(1, `ADDR_SECOND_TIMER_PERIOD, 8'h00);
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h11);
      wait_pulse(0, n);
      repeat (3) @(posedge clk_in);
      `CHK("irq first", 1'b1, irq_out)
      bus(0, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
      `CHK("first flag set", 32'h00000013, rd)
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h01);
      repeat (3) @(posedge clk_in);
      `CHK("irq first cleared", 1'b0, irq_out)
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h44);
      wait_pulse(1, n);
      repeat (3) @(posedge clk_in);
      `CHK("irq second", 1'b1, irq_out)
      bus(0, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
      `CHK("second flag set", 32'h0000004C, rd)
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
      repeat (3) @(posedge clk_in);
      `CHK("irq masked", 1'b0, irq_out)
      bus(1, `ADDR_EVENT_MASK, 8'h02);
      repeat (3) @(posedge clk_in);
      `CHK("irq unmasked event", 1'b1, irq_out)
      bus(1, `ADDR_EVENT_STATUS, 8'h03);
      repeat (3) @(posedge clk_in);
      `CHK("irq event cleared", 1'b0, irq_out)
      bus(1, `ADDR_EVENT_MASK, 8'h00);
    end
  endtask

  // Period write restart, then a flag clear with and without a coincident set
  task t_restart;
    int d, n;
    begin
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'h03);
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h10);
      wait_pulse(0, n);
      repeat (5) @(posedge clk_in);
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'h01);
      wait_pulse(0, n);
      `CHK("restart gap", 2 * 4 + 1, n)
      bus(1, `ADDR_FIRST_TIMER_PERIOD, 8'h03);
      for (d = 13; d <= 14; d++) begin
        wait_pulse(0, n);
        repeat (d) @(posedge clk_in);
        bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h10);
        bus(0, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
        `CHK("flag after clear", (d == 13), rd[1])
      end
      bus(1, `ADDR_DUAL_TIMER_CONTROL, 8'h00);
    end
  endtask

  // --------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // --------------------------------------------------------------------------
  task wrap_up;
    begin
      $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  initial begin
    // Scenarios need under two thousand cycles; allow ample margin
    #(5 * 20000);
    n_fail++;
    wrap_up;
  end

  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_rates;
    t_irq;
    t_restart;
    wrap_up;
  end
endmodule // tb_dual_8bit_interval_timer
